// file: src/npp_pkg.sv
// Package for the parallel programming port of the nonvolatile memories.
// Assumes a single 10 MHz clock domain; pins are synchronised inside the port.
package npp_pkg;
  // Clock rate in kHz and the byte-write time window.
  localparam int unsigned CLK_KHZ        = 10000;
  localparam int unsigned PROG_TIME_US   = 700;
  localparam int unsigned PROG_MIN_US    = 500;
  localparam int unsigned PROG_MAX_US    = 900;
  localparam int unsigned PROG_CYCLES    = PROG_TIME_US * CLK_KHZ / 1000;
  localparam int unsigned PROG_MIN_CYC   = (PROG_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned PROG_MAX_CYC   = PROG_MAX_US * CLK_KHZ / 1000;
  // Entry hold time of byte select around the high voltage.
  localparam int unsigned ENTRY_HOLD_NS  = 100;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned ENTRY_CYC      = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Action select codes.
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  // Command bytes.
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR  = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR  = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR    = 8'h11;
  localparam logic [7:0] CMD_SIG_RD   = 8'h08;
  localparam logic [7:0] CMD_FL_RD    = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD    = 8'h03;

  // Memory geometry and field layout.
  localparam int unsigned FLASH_AW  = 11;
  localparam int unsigned EE_AW     = 8;
  localparam int unsigned FUSE_W    = 6;
  localparam int unsigned LOCK_LO   = 1;
  localparam int unsigned LOCK_HI   = 2;
  localparam logic [7:0] ERASED     = 8'hff;
  localparam logic [5:0] FUSE_RST   = 6'h1a;
  localparam logic [1:0] LOCK_RST   = 2'h3;
  localparam logic [7:0] SIG_B0     = 8'h5a; // Arbitrary value.
  localparam logic [7:0] SIG_B1     = 8'ha5; // Arbitrary value.
  localparam logic [7:0] SIG_B2     = 8'h3c; // Arbitrary value.

  typedef enum logic [1:0] {
    NPP_OFF   = 2'b00,
    NPP_ENTRY = 2'b01,
    NPP_IDLE  = 2'b11,
    NPP_BUSY  = 2'b10
  } npp_state_e;
endpackage

// file: src/npp_sync.sv
// Two flip-flop synchroniser for a bundle of pins.
// Assumes the pins are asynchronous to mclk_in.
`timescale 1ns/1ps
module npp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         mclk_in,
  input  wire logic         resetn_in,
  // Pins and their synchronised copy.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } npp_sy_s;
  npp_sy_s st_ff, nxt_st;

  // Only the second stage reads the first.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    if (!resetn_in) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st_ff <= nxt_st;
  end

  assign sync_out = st_ff.s2;
endmodule

// file: src/npp_port.sv
// Parallel programming port: flash, EEPROM, fuse and lock access by pins.
// Assumes one 10 MHz clock; all pins are asynchronous and get synchronised.
// What this block does
// RULE1: crystal pulse acts on action select
// RULE2: address byte goes high/low by byte_select
// RULE3: data byte goes high/low by byte_select
// RULE4: decode erase, fuse write, lock write
// RULE5: decode flash write and EEPROM write
// RULE6: decode flash, EEPROM, signature, fuse reads
// RULE7: ready low while programming in progress
// RULE8: drive data only while output enable low
// RULE9: programmer holds reset, byte_select low first
// RULE10: byte_select change after high voltage aborts
// RULE11: erase clears arrays, then locks, keeps fuses
// RULE12: erase shows no busy on ready
// RULE13: programmer erases before reprogramming memories
// RULE14: write strobe starts timed byte programming
// RULE15: programmer waits ready before next write
// RULE16: command and address kept across operations
// RULE17: address high byte kept until reloaded
// RULE18: flash read gives low/high byte by byte_select
// RULE19: EEPROM uses low address and data
// RULE20: fuse write maps low data bits
// RULE21: fuse write shows no ready activity
// RULE22: lock write programs only zero bits
// RULE23: programmer erase pulse 5 to 15 ms; the model drives ERASE_CYC = 60 cycles (6 us)
// RULE24: programmer fuse pulse 1.0 to 1.8 ms; the model drives FUSE_CYC = 30 cycles (3 us)
// RULE25: ready returns 0.5 to 0.9 ms after strobe
// RULE26: ignore strobes and loads while busy
// RULE27: eight bit bus, released when enable high
`timescale 1ns/1ps
module npp_port
  import npp_pkg::*;
#(
  parameter int unsigned PROG_CYC = npp_pkg::PROG_CYCLES
) (
  // Clock and reset.
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // Programming mode entry: high voltage seen on reset pin.
  input  wire logic       hv_reset_in,
  // Control pins.
  input  wire logic       crystal_input_in,
  input  wire logic       action_select_0_in,
  input  wire logic       action_select_1_in,
  input  wire logic       byte_select_in,
  input  wire logic       write_n_in,
  input  wire logic       output_enable_n_in,
  // Data bus as three signals.
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_out,
  // Status.
  output logic            ready_not_busy_out,
  output logic            prog_mode_out,
  output logic [5:0]      fuse_bits_out,
  output logic [1:0]      lock_bits_out
);
  import npp_pkg::*;

  localparam int unsigned NSYNC = 15;
  localparam int unsigned CW    = $clog2(PROG_CYC + 1);
  localparam logic [CW-1:0] PROG_END = CW'(PROG_CYC - 1);
  localparam logic [1:0] ENTRY_END = 2'(ENTRY_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise every pin before use.
  logic [NSYNC-1:0] pins_s;
  npp_sync #(.W(NSYNC)) u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  ({hv_reset_in, crystal_input_in, action_select_1_in, action_select_0_in,
                 byte_select_in, write_n_in, output_enable_n_in, data_in}),
    .sync_out  (pins_s)
  );
  logic       hv_s, xt_s, bs_s, wr_n_s, oe_n_s;
  logic [1:0] act_s;
  logic [7:0] d_s;
  assign hv_s   = pins_s[14];
  assign xt_s   = pins_s[13];
  assign act_s  = pins_s[12:11];
  assign bs_s   = pins_s[10];
  assign wr_n_s = pins_s[9];
  assign oe_n_s = pins_s[8];
  assign d_s    = pins_s[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Memories. Arrays sit outside the state struct to keep it small.
  logic [7:0] flash_lo [0:(1<<FLASH_AW)-1];
  logic [7:0] flash_hi [0:(1<<FLASH_AW)-1];
  logic [7:0] eeprom   [0:(1<<EE_AW)-1];

  typedef struct packed {
    npp_state_e       state;
    logic [1:0]       entry_cnt;
    logic             entry_fail;
    logic             xt_d;
    logic             wr_n_d;
    logic [7:0]       cmd;
    logic [7:0]       addr_hi;
    logic [7:0]       addr_lo;
    logic [7:0]       dat_hi;
    logic [7:0]       dat_lo;
    logic [CW-1:0]    cnt;
    logic             wr_hi;
    logic             wr_ee;
    logic             erase_run;
    logic [FLASH_AW-1:0] erase_ptr;
    logic [FUSE_W-1:0] fuse;
    logic [1:0]       lock;
    logic [7:0]       dout;
    logic             doe;
    logic             rdy;
    logic             pm;
  } npp_st_s;
  npp_st_s st_ff, nxt_st;

  logic [FLASH_AW-1:0] faddr;
  logic [7:0]          rd_byte;
  logic                xt_rise, wr_fall;
  assign faddr   = {st_ff.addr_hi[FLASH_AW-9:0], st_ff.addr_lo}; // RULE17
  assign xt_rise = xt_s & ~st_ff.xt_d;
  assign wr_fall = ~wr_n_s & st_ff.wr_n_d;

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, chosen by the latched command.
  always_comb begin
    rd_byte = ERASED;
    case (st_ff.cmd) // RULE6
      CMD_FLASH_RD: rd_byte = bs_s ? flash_hi[faddr] : flash_lo[faddr]; // RULE18
      CMD_EE_RD:    rd_byte = eeprom[st_ff.addr_lo]; // RULE19
      CMD_SIG_RD: begin
        case (st_ff.addr_lo)
          8'h00:   rd_byte = SIG_B0;
          8'h01:   rd_byte = SIG_B1;
          8'h02:   rd_byte = SIG_B2;
          default: rd_byte = 8'h00;
        endcase
      end
      // Fuse and lock bits read back with the reserved bits shown unprogrammed.
      CMD_FL_RD:    rd_byte = bs_s ? {5'h1f, st_ff.lock, 1'b1} : {2'h3, st_ff.fuse};
      default:      rd_byte = ERASED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state machine.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.xt_d   = xt_s;
    nxt_st.wr_n_d = wr_n_s;
    // Bus driven only with output enable low in programming mode.
    nxt_st.doe  = (st_ff.state == NPP_IDLE) & ~oe_n_s; // RULE8 RULE27
    nxt_st.dout = rd_byte;
    // The erase sweep runs in every state, so a dropped high voltage or a byte write
    // started during the sweep cannot leave the arrays half erased. It comes before the
    // strobe decode so that a new erase started on the last sweep cycle wins.
    if (st_ff.erase_run) begin
      nxt_st.erase_ptr = st_ff.erase_ptr + 1'b1;
      if (&st_ff.erase_ptr) begin
        nxt_st.erase_run = 1'b0;
        nxt_st.lock      = LOCK_RST; // RULE11
      end
    end
    case (st_ff.state)
      NPP_OFF: begin
        // A failed entry stays failed until the high voltage is removed.
        if (!hv_s) begin
          nxt_st.entry_fail = 1'b0;
        end else if (!bs_s && !st_ff.entry_fail) begin
          nxt_st.state     = NPP_ENTRY;
          nxt_st.entry_cnt = 2'h0;
        end
      end
      NPP_ENTRY: begin
        // Byte select must stay still while high voltage settles; one blip locks entry out.
        if (bs_s) begin // RULE10
          nxt_st.state      = NPP_OFF;
          nxt_st.entry_fail = 1'b1;
        end else if (!hv_s) begin
          nxt_st.state = NPP_OFF;
        end else if (st_ff.entry_cnt >= ENTRY_END) begin
          nxt_st.state = NPP_IDLE;
        end else begin
          nxt_st.entry_cnt = st_ff.entry_cnt + 2'h1;
        end
      end
      NPP_IDLE: begin
        if (xt_rise) begin
          case (act_s) // RULE1
            ACT_ADDR: if (bs_s) nxt_st.addr_hi = d_s; else nxt_st.addr_lo = d_s; // RULE2
            ACT_DATA: if (bs_s) nxt_st.dat_hi = d_s; else nxt_st.dat_lo = d_s; // RULE3
            ACT_CMD:  nxt_st.cmd = d_s; // RULE16
            default:  nxt_st.cmd = st_ff.cmd;
          endcase
        end else if (wr_fall) begin
          case (st_ff.cmd) // RULE4 RULE5
            CMD_FLASH_WR, CMD_EE_WR: begin
              if (st_ff.lock[0]) begin
                nxt_st.state = NPP_BUSY; // RULE14
                nxt_st.cnt   = '0;
                nxt_st.wr_hi = bs_s & (st_ff.cmd == CMD_FLASH_WR);
                nxt_st.wr_ee = (st_ff.cmd == CMD_EE_WR);
              end
            end
            CMD_ERASE: begin
              nxt_st.erase_run = 1'b1; // RULE12
              nxt_st.erase_ptr = '0;
            end
            CMD_FUSE_WR: if (st_ff.lock[0]) nxt_st.fuse = st_ff.dat_lo[FUSE_W-1:0]; // RULE20 RULE21
            CMD_LOCK_WR: nxt_st.lock = st_ff.lock & {st_ff.dat_lo[LOCK_HI], st_ff.dat_lo[LOCK_LO]}; // RULE22
            default:     nxt_st.cmd = st_ff.cmd;
          endcase
        end
      end
      NPP_BUSY: begin
        // Strobes and loads are ignored here.
        nxt_st.cnt = st_ff.cnt + 1'b1; // RULE26
        if (st_ff.cnt == PROG_END) begin
          nxt_st.state = NPP_IDLE; // RULE25
        end
      end
      default: nxt_st.state = NPP_OFF;
    endcase
    if (!hv_s && st_ff.state != NPP_OFF) begin
      nxt_st.state = NPP_OFF;
      nxt_st.doe   = 1'b0;
    end
    if (!resetn_in) begin
      nxt_st       = '0;
      nxt_st.state = NPP_OFF;
      nxt_st.fuse  = FUSE_RST;
      nxt_st.lock  = LOCK_RST;
      nxt_st.xt_d  = 1'b0;
      nxt_st.wr_n_d = 1'b1;
    end
    // Status outputs are registered from the next state, so they carry no decode
    // glitches yet keep the same timing as the state itself.
    nxt_st.rdy = (nxt_st.state != NPP_BUSY); // RULE7
    nxt_st.pm  = (nxt_st.state == NPP_IDLE) || (nxt_st.state == NPP_BUSY);
  end

  always_ff @(posedge mclk_in) begin
    st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array writes. The byte is stored at the end of the timed write.
  always_ff @(posedge mclk_in) begin
    if (st_ff.erase_run) begin
      flash_lo[st_ff.erase_ptr] <= ERASED; // RULE11
      flash_hi[st_ff.erase_ptr] <= ERASED;
      eeprom[st_ff.erase_ptr[EE_AW-1:0]] <= ERASED;
    end else if (st_ff.state == NPP_BUSY && st_ff.cnt == PROG_END) begin
      if (st_ff.wr_ee) begin
        eeprom[st_ff.addr_lo] <= st_ff.dat_lo; // RULE19
      end else if (st_ff.wr_hi) begin
        flash_hi[faddr] <= st_ff.dat_hi;
      end else begin
        flash_lo[faddr] <= st_ff.dat_lo;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops.
  assign data_out           = st_ff.dout;
  assign data_oe_out        = st_ff.doe;
  assign ready_not_busy_out = st_ff.rdy; // RULE7
  assign prog_mode_out      = st_ff.pm;
  assign fuse_bits_out      = st_ff.fuse;
  assign lock_bits_out      = st_ff.lock;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Independent count of busy cycles; a delay range cannot reach the byte-write
  // time, so the length is checked on this counter instead.
  logic [CW-1:0] chk_busy_ff;
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || ready_not_busy_out) begin
      chk_busy_ff <= '0;
    end else begin
      chk_busy_ff <= chk_busy_ff + 1'b1;
    end
  end

  // A busy period ended by a dropped high voltage is not a finished write.
  property p_busy_len;
    @(posedge mclk_in) disable iff (!resetn_in)
      ($rose(ready_not_busy_out) && prog_mode_out) |-> chk_busy_ff == CW'(PROG_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length out of range"); // RULE25

  property p_oe_bus;
    @(posedge mclk_in) disable iff (!resetn_in)
      data_oe_out |-> $past(~oe_n_s);
  endproperty
  a_oe_bus: assert property (p_oe_bus) else $error("bus driven without output enable"); // RULE8

  property p_erase_nobusy;
    @(posedge mclk_in) disable iff (!resetn_in)
      st_ff.erase_run |-> ready_not_busy_out;
  endproperty
  a_erase_nobusy: assert property (p_erase_nobusy) else $error("busy during erase"); // RULE12

  property p_busy_hold;
    @(posedge mclk_in) disable iff (!resetn_in)
      !ready_not_busy_out |=> $stable(st_ff.cmd) && $stable(st_ff.addr_lo) && $stable(st_ff.dat_lo);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("latches changed while busy"); // RULE26

  property p_cmd_latch;
    @(posedge mclk_in) disable iff (!resetn_in)
      (st_ff.state == NPP_IDLE && xt_rise && act_s == ACT_CMD && hv_s) |=> st_ff.cmd == $past(d_s);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command not latched"); // RULE1

  property p_addr_hi;
    @(posedge mclk_in) disable iff (!resetn_in)
      (st_ff.state == NPP_IDLE && xt_rise && act_s == ACT_ADDR && bs_s && hv_s) |=> st_ff.addr_hi == $past(d_s);
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address high not latched"); // RULE2

  property p_lock_only_prog;
    @(posedge mclk_in) disable iff (!resetn_in)
      (!st_ff.erase_run && st_ff.state != NPP_OFF) |=> (st_ff.lock & ~$past(st_ff.lock)) == 2'h0;
  endproperty
  a_lock_only_prog: assert property (p_lock_only_prog) else $error("lock unprogrammed without erase"); // RULE22

  property p_bs_abort;
    @(posedge mclk_in) disable iff (!resetn_in)
      (st_ff.state == NPP_ENTRY && bs_s) |=> st_ff.state == NPP_OFF;
  endproperty
  a_bs_abort: assert property (p_bs_abort) else $error("entry not aborted"); // RULE10

  property p_fuse_wr;
    @(posedge mclk_in) disable iff (!resetn_in)
      (st_ff.state == NPP_IDLE && wr_fall && !xt_rise && hv_s && st_ff.lock[0] && st_ff.cmd == CMD_FUSE_WR)
        |=> fuse_bits_out == $past(st_ff.dat_lo[FUSE_W-1:0]);
  endproperty
  a_fuse_wr: assert property (p_fuse_wr) else $error("fuse bits not taken from the data byte"); // RULE20

  // Main scenarios: byte write, erase sweep, read, entry and a refused entry.
  c_write:  cover property (@(posedge mclk_in) $fell(ready_not_busy_out));
  c_erase:  cover property (@(posedge mclk_in) $fell(st_ff.erase_run));
  c_read:   cover property (@(posedge mclk_in) data_oe_out && st_ff.cmd == CMD_FLASH_RD);
  c_enter:  cover property (@(posedge mclk_in) $rose(prog_mode_out));
  c_abort:  cover property (@(posedge mclk_in) $rose(st_ff.entry_fail));
endmodule

// file: dv/npp_prog_model.sv
// Programmer model: drives the pins of the parallel programming port.
// Assumes it shares mclk_in with the port; pins change just after rising edges.
`timescale 1ns/1ps
module npp_prog_model #(
  parameter int unsigned ERASE_CYC = 60, // Short stand-in for the erase pulse width.
  parameter int unsigned FUSE_CYC  = 30  // Short stand-in for the fuse pulse width.
) (
  // Clock and device status.
  input  wire logic       mclk_in,
  input  wire logic       ready_in,
  // Device side of the data bus.
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  // Pins toward the device.
  output logic            hv_out,
  output logic            xtal_out,
  output logic [1:0]      act_out,
  output logic            bs_out,
  output logic            wr_n_out,
  output logic            oe_n_out,
  output logic [7:0]      bus_out
);
  logic [7:0] dat_ff;
  ////////////////////////////////////////////////
  // A bus the device does not drive shows the inverse byte while output enable is low, so a stale value never reads back by luck.
  assign bus_out = dev_oe_in ? dev_data_in : (oe_n_out ? dat_ff : ~dat_ff);
  // Idle pin levels at time zero.
  initial begin
    {hv_out, xtal_out, bs_out, dat_ff} = '0;
    {act_out, wr_n_out, oe_n_out} = 4'hf;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // Reset low with byte select low first; a glitch on byte select just after entry is optional.
  task automatic enter(input logic glitch);
    tick(1);
    hv_out <= 1'b0;
    bs_out <= 1'b0;
    tick(4);
    hv_out <= 1'b1;
    if (glitch) begin
      tick(1);
      bs_out <= 1'b1;
      tick(1);
      bs_out <= 1'b0;
    end
    tick(12);
  endtask
  // Pins are held four cycles around each crystal edge because the port synchronises them.
  task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
    tick(1);
    act_out <= act;
    bs_out  <= bs;
    dat_ff  <= d;
    tick(4);
    xtal_out <= 1'b1;
    tick(4);
    xtal_out <= 1'b0;
    tick(4);
  endtask
  // Write strobe of n cycles; the caller picks the erase or fuse width.
  task automatic pulse(input logic bs, input int n);
    tick(1);
    bs_out <= bs;
    tick(4);
    wr_n_out <= 1'b0;
    tick(n);
    wr_n_out <= 1'b1;
    tick(4);
  endtask
  task automatic read(input logic bs);
    tick(1);
    bs_out <= bs;
    tick(4);
    oe_n_out <= 1'b0;
    tick(6);
    oe_n_out <= 1'b1;
    tick(6);
  endtask
  // Bounded wait for ready before the next byte write.
  task automatic wait_ready();
    for (int i = 0; i < 2000 && !ready_in; i++) tick(1);
  endtask
endmodule

// file: dv/npp_port_bench.sv
// Self-checking bench for npp_port driven through the programmer model.
// Assumes a 10 MHz clock and a short byte-write time set by PROG_CYC.
`timescale 1ns/1ps
module npp_port_bench;
  import npp_pkg::*;
  localparam int unsigned PCYC = 40;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hv, xtal, bs, wr_n, oe_n, oe, rdy, pm;
  logic [1:0] act, lock;
  logic [7:0] bus, dout;
  logic [5:0] fuse, fv;
  logic [15:0] busy_cnt = '0;
  logic [7:0] rd_q[$], wd[3][2], ah, al, ea, ed;
  logic [15:0] busy_q[$];
  int err_count = 0, cmp_count = 0, cyc = 0, oe_cnt = 0;
  ////////////////////////////////////////////////
  always #50 mclk_in = ~mclk_in;
  npp_port #(.PROG_CYC(PCYC)) npp_port_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .hv_reset_in(hv),
    .crystal_input_in(xtal), .action_select_0_in(act[0]), .action_select_1_in(act[1]),
    .byte_select_in(bs), .write_n_in(wr_n), .output_enable_n_in(oe_n), .data_in(bus), .data_out(dout),
    .data_oe_out(oe), .ready_not_busy_out(rdy), .prog_mode_out(pm), .fuse_bits_out(fuse),
    .lock_bits_out(lock));
  npp_prog_model npp_prog_model_i (.mclk_in(mclk_in), .ready_in(rdy), .dev_data_in(dout),
    .dev_oe_in(oe), .hv_out(hv), .xtal_out(xtal), .act_out(act), .bs_out(bs), .wr_n_out(wr_n),
    .oe_n_out(oe_n), .bus_out(bus));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    npp_prog_model_i.load(ACT_CMD, 1'b0, c);
  endtask
  // Byte write that must show one busy period of PCYC cycles.
  task automatic wr(input logic b);
    busy_q.push_back(16'(PCYC));
    npp_prog_model_i.pulse(b, 4);
    npp_prog_model_i.wait_ready();
  endtask
  task automatic rd(input logic b, input logic [7:0] e);
    rd_q.push_back(e);
    npp_prog_model_i.read(b);
    chk(oe, 0);
  endtask
  // Erase pulse, then wait out the internal sweep; any busy here is reported as unexpected.
  task automatic erase();
    cmd(CMD_ERASE);
    npp_prog_model_i.pulse(1'b0, npp_prog_model_i.ERASE_CYC);
    npp_prog_model_i.tick(2100);
  endtask
  ////////////////////////////////////////////////
  // Watcher: each busy period and each driven read is matched to the oldest note.
  always @(posedge mclk_in) begin
    if (resetn_in && !rdy) busy_cnt <= busy_cnt + 16'h1;
    else if (busy_cnt != 0) begin
      chk(busy_cnt, busy_q.size() ? busy_q.pop_front() : 16'h0);
      busy_cnt <= '0;
    end
    oe_cnt = oe ? oe_cnt + 1 : 0;
    if (oe_cnt == 2) chk(dout, rd_q.size() ? rd_q.pop_front() : 8'h0);
  end
  // Hang guard.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////
  // Main sequence: entry, erase, flash, EEPROM, signature, fuse, lock, erase again.
  initial begin
    void'($urandom(2));
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    #1 chk({rdy, pm, fuse, lock, oe}, {2'b10, FUSE_RST, LOCK_RST, 1'b0});
    npp_prog_model_i.enter(1'b1);
    #1 chk(pm, 0);
    npp_prog_model_i.enter(1'b0);
    #1 chk(pm, 1);
    erase();
    ah = 8'($urandom_range(7, 0));
    al = 8'($urandom_range(250, 0));
    cmd(CMD_FLASH_WR);
    npp_prog_model_i.load(ACT_ADDR, 1'b1, ah);
    for (int i = 0; i < 3; i++) begin
      npp_prog_model_i.load(ACT_ADDR, 1'b0, al + 8'(i));
      for (int b = 0; b < 2; b++) begin
        wd[i][b] = 8'($urandom);
        npp_prog_model_i.load(ACT_DATA, b[0], wd[i][b]);
        busy_q.push_back(16'(PCYC));
        npp_prog_model_i.pulse(b[0], 4);
        if (i == 0 && b == 0) npp_prog_model_i.pulse(1'b1, 4);
        npp_prog_model_i.wait_ready();
      end
    end
    cmd(CMD_FLASH_RD);
    for (int i = 0; i < 3; i++) begin
      npp_prog_model_i.load(ACT_ADDR, 1'b0, al + 8'(i));
      rd(1'b0, wd[i][0]);
      rd(1'b1, wd[i][1]);
    end
    ea = 8'($urandom);
    ed = 8'($urandom);
    cmd(CMD_EE_WR);
    npp_prog_model_i.load(ACT_ADDR, 1'b0, ea);
    npp_prog_model_i.load(ACT_DATA, 1'b0, ed);
    wr(1'b0);
    cmd(CMD_EE_RD);
    rd(1'b0, ed);
    cmd(CMD_SIG_RD);
    for (int k = 0; k < 4; k++) begin
      npp_prog_model_i.load(ACT_ADDR, 1'b0, 8'(k));
      rd(1'b0, k == 0 ? SIG_B0 : k == 1 ? SIG_B1 : k == 2 ? SIG_B2 : 8'h00);
    end
    fv = 6'($urandom);
    cmd(CMD_FUSE_WR);
    npp_prog_model_i.load(ACT_DATA, 1'b0, {2'b11, fv});
    npp_prog_model_i.pulse(1'b0, npp_prog_model_i.FUSE_CYC);
    #1 chk(fuse, fv);
    cmd(CMD_FL_RD);
    rd(1'b0, {2'b11, fv});
    cmd(CMD_LOCK_WR);
    npp_prog_model_i.load(ACT_DATA, 1'b0, 8'hfd);
    npp_prog_model_i.pulse(1'b0, 4);
    npp_prog_model_i.load(ACT_DATA, 1'b0, 8'hff);
    npp_prog_model_i.pulse(1'b0, 4);
    #1 chk(lock, 2'b10);
    cmd(CMD_FL_RD);
    rd(1'b1, 8'hfd);
    cmd(CMD_FLASH_WR);
    npp_prog_model_i.pulse(1'b0, 4);
    npp_prog_model_i.tick(60);
    erase();
    #1 chk({fuse, lock}, {fv, LOCK_RST});
    cmd(CMD_FLASH_RD);
    npp_prog_model_i.load(ACT_ADDR, 1'b0, al);
    rd(1'b0, ERASED);
    rd(1'b1, ERASED);
    cmd(CMD_EE_RD);
    npp_prog_model_i.load(ACT_ADDR, 1'b0, ea);
    rd(1'b0, ERASED);
    npp_prog_model_i.tick(8);
    chk(16'(busy_q.size() + rd_q.size()), 0);
    finish_test();
  end
endmodule
